/* bench/sfb_link_checker.sv */
// Purpose: timing checks on the link and on busy for the flash buffer pair
// Assumes: one clock domain, async active-low reset
// Notes: busy lengths arrive as cycle counts from the bench
`timescale 1ns/1ns
module sfb_link_checker #(
    parameter int EP_C = 300,
    parameter int P_C  = 300,
    parameter int PE_C = 300,
    parameter int BE_C = 2200
)(
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic so_oe,
    input  wire logic busy_o,
    input  wire logic cmd_ready_o
);
    logic [15:0] bcnt;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // busy run length; cleared when idle so each run is judged alone
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) bcnt <= 16'h0000;
        else if (busy_o) bcnt <= bcnt + 16'h0001;
        else bcnt <= 16'h0000;
    end

    property p_so_release;
        cs_n |-> !so_oe;
    endproperty
    a_so_release: assert property (p_so_release) else $error("so driven while deselected");
    property p_sck_idle;
        cs_n |-> !sck;
    endproperty
    a_sck_idle: assert property (p_sck_idle) else $error("sck moves outside a frame");
    property p_si_stable;
        !cs_n && $rose(sck) |-> $stable(si);
    endproperty
    a_si_stable: assert property (p_si_stable) else $error("si changed at sck rise");
    property p_busy_start;
        $rose(busy_o) |-> cs_n && (!$past(cs_n, 1) || !$past(cs_n, 2) || !$past(cs_n, 3));
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy without frame end");
    property p_busy_len;
        $fell(busy_o) |-> (bcnt == EP_C || bcnt == P_C || bcnt == PE_C || bcnt == BE_C);
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy run has wrong length");
    property p_ready_busy;
        busy_o |-> !cmd_ready_o;
    endproperty
    a_ready_busy: assert property (p_ready_busy) else $error("host ready while busy");
    property p_busy_no_frame;
        busy_o |-> cs_n;
    endproperty
    a_busy_no_frame: assert property (p_busy_no_frame) else $error("frame during busy");
    property p_cs_gap;
        $rose(cs_n) |=> cs_n[*2];
    endproperty
    a_cs_gap: assert property (p_cs_gap) else $error("deselect gap too short");
    property p_oe_in_frame;
        $rose(so_oe) |-> !cs_n && !sck;
    endproperty
    a_oe_in_frame: assert property (p_oe_in_frame) else $error("so enabled off frame");
endmodule

/* bench/tb_serial_flash_buffer_program_erase.sv */
// Purpose: host and device ends joined; buffer wrap and self-timed busy runs
// Assumes: both ends share page256 and busy
// Notes: short time parameters keep busy runs brief
`timescale 1ns/1ns
module tb_serial_flash_buffer_program_erase
    import sfb_pkg::*;
;
    localparam int EP_C = 600;
    localparam int P_C  = 300;
    localparam int PE_C = 300;
    localparam int BE_C = 2200;
    logic        clk_i     = 1'b0;
    logic        resetn_i  = 1'b0;
    logic        page256   = 1'b0;
    logic        cmd_valid = 1'b0;
    logic [7:0]  cmd_op    = 8'h00;
    logic [8:0]  cmd_page  = 9'h000;
    logic [8:0]  cmd_buf   = 9'h000;
    logic [15:0] cmd_len   = 16'h0000;
    logic [7:0]  wq [0:7];
    logic [2:0]  wi        = 3'd0;
    logic [7:0]  wr_data;
    logic [7:0]  rd_data;
    logic        wr_take;
    logic        cmd_ready;
    logic        rd_valid;
    logic        busy;
    logic [7:0]  rq [$];
    int          err_total  = 0;
    int          num_checks = 0;

    sfb_if link ();
    // erase plus program walks 528 cycles, so its window must exceed that
    sfb_dev #(.ERASE_PROGRAM_TIME_MAX_US(6), .PROGRAM_TIME_MAX_US(3),
              .PAGE_ERASE_TIME_MAX_US(3), .BLOCK_ERASE_TIME_MAX_US(22)) i_sfb_dev (
        .clk_i(clk_i), .resetn_i(resetn_i), .link(link), .page256_i(page256), .busy_o(busy));
    sfb_host i_sfb_host (
        .clk_i(clk_i), .resetn_i(resetn_i), .link(link), .page256_i(page256),
        .dev_busy_i(busy), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
        .cmd_op_i(cmd_op), .cmd_page_i(cmd_page), .cmd_buf_i(cmd_buf), .cmd_len_i(cmd_len),
        .wr_data_i(wr_data), .wr_take_o(wr_take), .rd_data_o(rd_data), .rd_valid_o(rd_valid));
    sfb_link_checker #(.EP_C(EP_C), .P_C(P_C), .PE_C(PE_C), .BE_C(BE_C)) i_sfb_link_checker (
        .clk_i(clk_i), .resetn_i(resetn_i), .cs_n(link.cs_n), .sck(link.sck), .si(link.si),
        .so_oe(link.so_oe), .busy_o(busy), .cmd_ready_o(cmd_ready));

    // clock, write source fed first-word-fall-through, read capture
    always #5 clk_i = ~clk_i;
    assign wr_data = wq[wi];
    always @(posedge clk_i) begin
        if (wr_take === 1'b1) wi <= wi + 3'd1;
        if (rd_valid === 1'b1) rq.push_back(rd_data);
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // one command through the host; returns busy cycles seen afterwards
    task automatic do_cmd(input logic [7:0] op, input logic [8:0] bi, input logic [15:0] len,
                          output int bcyc);
        int n;
        @(posedge clk_i);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_page <= 9'h1fb;
        cmd_buf <= bi;
        cmd_len <= len;
        wi <= 3'd0;
        rq.delete();
        n = 0;
        do begin @(negedge clk_i); n++; end while (cmd_ready !== 1'b1 && n < 5000);
        check(16'(cmd_ready), 16'd1);
        @(posedge clk_i);
        cmd_valid <= 1'b0;
        n = 0;
        do begin @(negedge clk_i); n++; end while (link.cs_n !== 1'b1 && n < 20000);
        check(16'(link.cs_n), 16'd1);
        // late rd_valid and busy rise land in the first few cycles here
        bcyc = 0;
        for (n = 0; n < 3000; n++) begin
            @(negedge clk_i);
            if (busy === 1'b1) bcyc++;
            else if (bcyc > 0 || n > 8) break;
        end
    endtask

    // write four bytes across the buffer end, read them back across it
    task automatic t_buf_wrap(input logic mode);
        int len;
        int b;
        @(posedge clk_i);
        page256 <= mode;
        len = mode ? PAGE_BYTES_BIN : PAGE_BYTES_STD;
        for (int i = 0; i < 8; i++) wq[i] = 8'(8'h30 + i + 16 * mode);
        do_cmd(OP_BUF_WR, 9'(len - 2), 16'd4, b);
        check(16'(b), 16'd0);
        do_cmd(OP_BUF_RD_FAST, 9'(len - 2), 16'd4, b);
        // 25 MHz link is above the slow read limit, so the fast opcode goes out
        check(16'(i_sfb_dev.opcode), 16'(OP_BUF_RD_FAST));
        check(16'(rq.size()), 16'd4);
        for (int i = 0; i < 4; i++) check(16'(rq[i]), 16'(wq[i]));
        check(16'(link.so_oe), 16'd0);
        $display("test buf_wrap mode=%0d done", mode);
    endtask

    // each self-timed command gives its own busy length; buffer survives
    task automatic t_timed(input logic mode);
        logic [7:0] ops [4];
        logic [7:0] mv [4];
        int lim [4];
        int len;
        int b;
        len = mode ? PAGE_BYTES_BIN : PAGE_BYTES_STD;
        ops = '{OP_PAGE_ERASE, OP_PROG_ERASE, OP_PROG, OP_BLOCK_ERASE};
        lim = '{PE_C, EP_C, P_C, BE_C};
        // page 507 byte 0: erased, then buffer byte 0, kept, erased again
        mv = '{ERASED_BYTE, wq[2], wq[2], ERASED_BYTE};
        for (int k = 0; k < 4; k++) begin
            do_cmd(ops[k], 9'h000, 16'd0, b);
            check(16'(b), 16'(lim[k]));
            check(16'(i_sfb_dev.mem[PAGE_BYTES_STD * 507]), 16'(mv[k]));
        end
        // another page of the same block of eight
        check(16'(i_sfb_dev.mem[PAGE_BYTES_STD * 504]), 16'(ERASED_BYTE));
        do_cmd(OP_BUF_RD_FAST, 9'(len - 2), 16'd4, b);
        for (int i = 0; i < 4; i++) check(16'(rq[i]), 16'(wq[i]));
        $display("test timed mode=%0d done", mode);
    endtask

    // watchdog sized well above the whole sequence
    initial begin
        repeat (40000) @(posedge clk_i);
        err_total++;
        $display("watchdog expired");
        end_of_test();
    end

    initial begin
        for (int i = 0; i < 8; i++) wq[i] = 8'h00;
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_buf_wrap(1'b0);
        t_timed(1'b0);
        t_buf_wrap(1'b1);
        t_timed(1'b1);
        end_of_test();
    end
endmodule

/* inc/sfb_if.sv */
// Purpose: serial link between host controller and flash device
// Assumes: device drives the SO wire at all times; so_oe only marks it valid
// Notes: chip select active low, no clocking block
`timescale 1ns/1ns
interface sfb_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    modport host (output cs_n, output sck, output si, input so, input so_oe);
    modport dev  (input cs_n, input sck, input si, output so, output so_oe);
endinterface

/* inc/sfb_pkg.sv */
// Purpose: shared constants and helpers for the serial flash buffer link
// Assumes: one 100 MHz clock on both ends; link is SPI mode 0
// Notes: opcodes, address field layout, walk sizes and time defaults
package sfb_pkg;
    localparam int         CLK_MHZ        = 100;
    localparam logic [7:0] OP_BUF_RD_FAST = 8'hd4;
    localparam logic [7:0] OP_BUF_RD_SLOW = 8'hd1;
    localparam logic [7:0] OP_BUF_WR      = 8'h84;
    localparam logic [7:0] OP_PROG_ERASE  = 8'h83;
    localparam logic [7:0] OP_PROG        = 8'h88;
    localparam logic [7:0] OP_PAGE_ERASE  = 8'h81;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
    localparam logic [7:0] ERASED_BYTE    = 8'hff;
    localparam int         PAGE_BYTES_STD = 264;
    localparam int         PAGE_BYTES_BIN = 256;
    localparam int         PAGES          = 512;
    localparam int         BLOCK_PAGES    = 8;
    localparam logic [2:0] HDR_BYTES      = 3'd4;  // opcode plus three address bytes
    localparam logic [2:0] RD_DATA_START  = 3'd5;  // after the dummy byte
    // self-timed maxima in microseconds; plain defaults
    localparam int EP_TIME_US_DEF = 40;
    localparam int P_TIME_US_DEF  = 30;
    localparam int PE_TIME_US_DEF = 30;
    localparam int BE_TIME_US_DEF = 40;
    localparam int SLOW_READ_CLOCK_LIMIT_MHZ_DEF = 20;

    // buffer index: low 9 bits in 264 mode, low 8 bits in 256 mode
    function automatic logic [8:0] buf_of(input logic [23:0] a, input logic bin);
        buf_of = bin ? {1'b0, a[7:0]} : a[8:0];
    endfunction
    // page number sits right above the buffer index field
    function automatic logic [8:0] page_of(input logic [23:0] a, input logic bin);
        page_of = bin ? a[16:8] : a[17:9];
    endfunction
    function automatic logic [23:0] make_addr(input logic [8:0] pg, input logic [8:0] b,
                                              input logic bin);
        make_addr = bin ? {7'h00, pg, b[7:0]} : {6'h00, pg, b};
    endfunction
    function automatic logic [8:0] wrap_inc(input logic [8:0] p, input logic [8:0] len);
        wrap_inc = (p == len - 9'h001) ? 9'h000 : p + 9'h001;
    endfunction
endpackage

/* logic/sfb_dev.sv */
// Purpose: flash device end: buffer read/write, program and erase sequencer
// Assumes: link pins synchronous to clk_i; host half period at least two cycles
// Notes: frames that start while busy are ignored whole
`timescale 1ns/1ns
module sfb_dev
    import sfb_pkg::*;
#(
    parameter int PAGE_COUNT                = PAGES,
    parameter int ERASE_PROGRAM_TIME_MAX_US = EP_TIME_US_DEF,
    parameter int PROGRAM_TIME_MAX_US       = P_TIME_US_DEF,
    parameter int PAGE_ERASE_TIME_MAX_US    = PE_TIME_US_DEF,
    parameter int BLOCK_ERASE_TIME_MAX_US   = BE_TIME_US_DEF
)(
    input  wire logic clk_i,
    input  wire logic resetn_i,
    sfb_if.dev        link,
    input  wire logic page256_i,
    output logic      busy_o
);
    localparam int EP_CYC = ERASE_PROGRAM_TIME_MAX_US * CLK_MHZ;
    localparam int P_CYC  = PROGRAM_TIME_MAX_US * CLK_MHZ;
    localparam int PE_CYC = PAGE_ERASE_TIME_MAX_US * CLK_MHZ;
    localparam int BE_CYC = BLOCK_ERASE_TIME_MAX_US * CLK_MHZ;

    // the walk must fit inside the self-timed window
    if (EP_CYC <= 2 * PAGE_BYTES_STD || P_CYC <= PAGE_BYTES_STD ||
        PE_CYC <= PAGE_BYTES_STD || BE_CYC <= BLOCK_PAGES * PAGE_BYTES_STD ||
        PAGE_COUNT != PAGES) begin : g_chk
        $error("sfb_dev: timing or page count not supported");
    end

    typedef enum logic [1:0] {
        SQ_IDLE  = 2'b00,
        SQ_ERASE = 2'b01,
        SQ_PROG  = 2'b10,
        SQ_WAIT  = 2'b11
    } sfb_sq_t;

    logic [7:0]  buf_mem [PAGE_BYTES_STD];
    logic [7:0]  mem     [PAGE_COUNT * PAGE_BYTES_STD];
    logic        sck_q;
    logic        cs_q;
    logic        frame_ok;
    logic [2:0]  bit_cnt;
    logic [2:0]  byte_cnt;
    logic [7:0]  rx_sh;
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [8:0]  ptr;
    logic [7:0]  so_sh;
    logic        so_en;
    sfb_sq_t     sq;
    logic        do_prog;
    logic [8:0]  pg_base;
    logic [2:0]  pg_off;
    logic [2:0]  last_off;
    logic [8:0]  idx;
    logic [8:0]  walk_len;
    logic [31:0] timer;
    logic [31:0] limit;

    // edge and frame decode
    wire        busy      = (sq != SQ_IDLE);
    wire        cs_fall   = ~link.cs_n & cs_q;
    wire        cs_rise   = link.cs_n & ~cs_q;
    wire        active    = ~link.cs_n & (cs_fall ? ~busy : frame_ok);
    wire        sck_rise  = active & link.sck & ~sck_q;
    wire        sck_fall  = active & ~link.sck & sck_q;
    wire [7:0]  rx_byte   = {rx_sh[6:0], link.si};
    wire        byte_done = sck_rise & (bit_cnt == 3'd7);
    wire [8:0]  page_len  = page256_i ? 9'(PAGE_BYTES_BIN) : 9'(PAGE_BYTES_STD);
    wire        is_rd     = (opcode == OP_BUF_RD_FAST) || (opcode == OP_BUF_RD_SLOW);
    wire        is_wr     = (opcode == OP_BUF_WR);
    wire        is_pe     = (opcode == OP_PROG_ERASE);
    wire        is_p      = (opcode == OP_PROG);
    wire        is_er     = (opcode == OP_PAGE_ERASE);
    wire        is_be     = (opcode == OP_BLOCK_ERASE);
    wire        wr_en     = byte_done & is_wr & (byte_cnt >= HDR_BYTES);
    wire        rd_step   = sck_fall & is_rd & (byte_cnt >= RD_DATA_START);
    // a command cut short never reaches the sequencer
    wire        start_op  = cs_rise & frame_ok & (byte_cnt >= HDR_BYTES) &
                            (is_pe | is_p | is_er | is_be);
    wire [8:0]  cmd_page  = page_of(addr, page256_i);
    wire [8:0]  cur_page  = 9'(pg_base + {6'h00, pg_off});
    wire        idx_last  = (idx == walk_len - 9'h001);
    wire [31:0] cur_mem   = 32'(cur_page) * 32'(PAGE_BYTES_STD) + 32'(idx);

    // serial receive, address capture and read-out shifting
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sck_q    <= 1'b0;
            cs_q     <= 1'b1;
            frame_ok <= 1'b0;
            bit_cnt  <= 3'd0;
            byte_cnt <= 3'd0;
            rx_sh    <= 8'h00;
            opcode   <= 8'h00;
            addr     <= 24'h000000;
            ptr      <= 9'h000;
            so_sh    <= 8'h00;
            so_en    <= 1'b0;
        end else begin
            sck_q <= link.sck;
            cs_q  <= link.cs_n;
            if (cs_fall) begin
                frame_ok <= ~busy;
            end
            if (link.cs_n) begin
                // chip select high closes every frame
                bit_cnt  <= 3'd0;
                byte_cnt <= 3'd0;
                so_en    <= 1'b0;
            end else begin
                if (sck_rise) begin
                    rx_sh   <= rx_byte;
                    bit_cnt <= bit_cnt + 3'd1;
                end
                if (byte_done) begin
                    if (byte_cnt != 3'd7) begin
                        byte_cnt <= byte_cnt + 3'd1;
                    end
                    if (byte_cnt == 3'd0) begin
                        opcode <= rx_byte;
                    end
                    if (byte_cnt >= 3'd1 && byte_cnt <= 3'd3) begin
                        addr <= {addr[15:0], rx_byte};
                    end
                    if (byte_cnt == 3'd3) begin
                        ptr <= buf_of({addr[15:0], rx_byte}, page256_i);
                    end
                end
                if (wr_en) begin
                    ptr <= wrap_inc(ptr, page_len);
                end
                if (rd_step) begin
                    so_en <= 1'b1;
                    if (bit_cnt == 3'd0) begin
                        so_sh <= buf_mem[ptr];
                        ptr   <= wrap_inc(ptr, page_len);
                    end else begin
                        so_sh <= {so_sh[6:0], 1'b0};
                    end
                end
            end
        end
    end

    // buffer store; only the serial write path loads it
    always_ff @(posedge clk_i) begin
        if (wr_en) begin
            buf_mem[ptr] <= rx_byte;
        end
    end

    // self-timed sequencer: erase walk, program walk, then hold busy
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sq       <= SQ_IDLE;
            do_prog  <= 1'b0;
            pg_base  <= 9'h000;
            pg_off   <= 3'd0;
            last_off <= 3'd0;
            idx      <= 9'h000;
            walk_len <= 9'(PAGE_BYTES_STD);
            timer    <= 32'd0;
            limit    <= 32'd0;
        end else begin
            timer <= busy ? timer + 32'd1 : 32'd0;
            case (sq)
                SQ_IDLE: begin
                    if (start_op) begin
                        do_prog  <= is_pe | is_p;
                        pg_base  <= is_be ? {cmd_page[8:3], 3'b000} : cmd_page;
                        last_off <= is_be ? 3'(BLOCK_PAGES - 1) : 3'd0;
                        pg_off   <= 3'd0;
                        idx      <= 9'h000;
                        walk_len <= page_len;
                        sq       <= is_p ? SQ_PROG : SQ_ERASE;
                        limit    <= is_pe ? 32'(EP_CYC) : is_p ? 32'(P_CYC) :
                                    is_er ? 32'(PE_CYC) : 32'(BE_CYC);
                    end
                end
                SQ_ERASE: begin
                    if (idx_last) begin
                        idx <= 9'h000;
                        if (pg_off == last_off) begin
                            pg_off <= 3'd0;
                            sq     <= do_prog ? SQ_PROG : SQ_WAIT;
                        end else begin
                            pg_off <= pg_off + 3'd1;
                        end
                    end else begin
                        idx <= idx + 9'h001;
                    end
                end
                SQ_PROG: begin
                    if (idx_last) begin
                        idx <= 9'h000;
                        sq  <= SQ_WAIT;
                    end else begin
                        idx <= idx + 9'h001;
                    end
                end
                SQ_WAIT: begin
                    // busy lasts the full documented maximum
                    if (timer >= limit - 32'd1) begin
                        sq <= SQ_IDLE;
                    end
                end
                default: sq <= SQ_IDLE;
            endcase
        end
    end

    // array writes come from the sequencer alone, never the buffer path
    always_ff @(posedge clk_i) begin
        if (sq == SQ_ERASE) begin
            mem[cur_mem] <= ERASED_BYTE;
        end else if (sq == SQ_PROG) begin
            // programming only clears bits, so an unerased page mixes
            mem[cur_mem] <= mem[cur_mem] & buf_mem[idx];
        end
    end

    assign link.so    = so_sh[7];
    assign link.so_oe = so_en & ~link.cs_n;
    assign busy_o     = busy;
endmodule

/* logic/sfb_host.sv */
// Purpose: host end: frames one command on the serial link per request
// Assumes: dev_busy_i carries the device busy indication
// Notes: sck made by divider from clk_i, mode 0, idle low
`timescale 1ns/1ns
module sfb_host
    import sfb_pkg::*;
#(
    parameter int SCK_DIV                   = 2,
    parameter int SLOW_READ_CLOCK_LIMIT_MHZ = SLOW_READ_CLOCK_LIMIT_MHZ_DEF
)(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    sfb_if.host              link,
    input  wire logic        page256_i,
    input  wire logic        dev_busy_i,
    input  wire logic        cmd_valid_i,
    output logic             cmd_ready_o,
    input  wire logic [7:0]  cmd_op_i,
    input  wire logic [8:0]  cmd_page_i,
    input  wire logic [8:0]  cmd_buf_i,
    input  wire logic [15:0] cmd_len_i,
    input  wire logic [7:0]  wr_data_i,
    output logic             wr_take_o,
    output logic [7:0]       rd_data_o,
    output logic             rd_valid_o
);
    if (SCK_DIV < 2 || SCK_DIV > 255) begin : g_chk
        $error("sfb_host: SCK_DIV out of range");
    end

    localparam int         SCK_MHZ = CLK_MHZ / (2 * SCK_DIV);
    localparam logic [7:0] RD_OP   = (SCK_MHZ <= SLOW_READ_CLOCK_LIMIT_MHZ) ?
                                     OP_BUF_RD_SLOW : OP_BUF_RD_FAST;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_XFER = 2'b01,
        HS_GAP  = 2'b10
    } sfb_hs_t;

    sfb_hs_t     hs;
    logic [7:0]  div_cnt;
    logic [2:0]  bit_cnt;
    logic [15:0] byte_idx;
    logic [15:0] total;
    logic [7:0]  op;
    logic [23:0] addr;
    logic [7:0]  tx_sh;
    logic [7:0]  rx_sh;

    // next byte selection and handshakes
    wire        tick     = (div_cnt == 8'(SCK_DIV - 1));
    wire        op_rd    = (op == OP_BUF_RD_FAST) || (op == OP_BUF_RD_SLOW);
    wire        c_rd     = (cmd_op_i == OP_BUF_RD_FAST) || (cmd_op_i == OP_BUF_RD_SLOW);
    wire        byte_end = (hs == HS_XFER) & tick & link.sck & (bit_cnt == 3'd7);
    wire [15:0] nxt_idx  = byte_idx + 16'd1;
    wire        last     = (nxt_idx == total);
    wire        load_nxt = byte_end & ~last;
    wire        accept   = cmd_valid_i & cmd_ready_o;
    wire [7:0]  nxt_byte = (nxt_idx == 16'd1) ? addr[23:16] :
                           (nxt_idx == 16'd2) ? addr[15:8]  :
                           (nxt_idx == 16'd3) ? addr[7:0]   :
                           op_rd ? 8'h00 : wr_data_i;

    // no new command while the device reports busy
    assign cmd_ready_o = (hs == HS_IDLE) & ~dev_busy_i;
    assign wr_take_o   = load_nxt & (op == OP_BUF_WR) & (nxt_idx >= 16'(HDR_BYTES));

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hs         <= HS_IDLE;
            div_cnt    <= 8'h00;
            bit_cnt    <= 3'd0;
            byte_idx   <= 16'h0000;
            total      <= 16'h0000;
            op         <= 8'h00;
            addr       <= 24'h000000;
            tx_sh      <= 8'h00;
            rx_sh      <= 8'h00;
            link.cs_n  <= 1'b1;
            link.sck   <= 1'b0;
            link.si    <= 1'b0;
            rd_data_o  <= 8'h00;
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= 1'b0;
            case (hs)
                HS_IDLE: begin
                    div_cnt <= 8'h00;
                    if (accept) begin
                        op        <= c_rd ? RD_OP : cmd_op_i;
                        tx_sh     <= c_rd ? RD_OP : cmd_op_i;
                        link.si   <= c_rd ? RD_OP[7] : cmd_op_i[7];
                        addr      <= make_addr(cmd_page_i, cmd_buf_i, page256_i);
                        total     <= 16'(HDR_BYTES) + (c_rd ? 16'd1 : 16'd0) + cmd_len_i;
                        byte_idx  <= 16'h0000;
                        bit_cnt   <= 3'd0;
                        link.cs_n <= 1'b0;
                        hs        <= HS_XFER;
                    end
                end
                HS_XFER: begin
                    div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
                    if (tick && !link.sck) begin
                        link.sck <= 1'b1;
                        rx_sh    <= {rx_sh[6:0], link.so};
                    end else if (tick) begin
                        link.sck <= 1'b0;
                        bit_cnt  <= bit_cnt + 3'd1;
                        if (bit_cnt == 3'd7) begin
                            byte_idx <= nxt_idx;
                            if (op_rd && byte_idx >= 16'(RD_DATA_START)) begin
                                rd_data_o  <= rx_sh;
                                rd_valid_o <= 1'b1;
                            end
                            if (last) begin
                                link.cs_n <= 1'b1;
                                hs        <= HS_GAP;
                            end else begin
                                tx_sh   <= nxt_byte;
                                link.si <= nxt_byte[7];
                            end
                        end else begin
                            tx_sh   <= {tx_sh[6:0], 1'b0};
                            link.si <= tx_sh[6];
                        end
                    end
                end
                HS_GAP: begin
                    // chip select high for one half period before idle
                    div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
                    if (tick) begin
                        hs <= HS_IDLE;
                    end
                end
                default: hs <= HS_IDLE;
            endcase
        end
    end
endmodule
